// File: hw/sbs_core.sv
// Skip, branch and system-control execution unit of an 8-bit core, with an APB register port.
// Assumes one 25 MHz clock, inputs synchronous to it, and an APB master that holds its request.
//
// What this block does
// - Compare-not-equal immediate skips when accumulator differs; flags as a subtraction.
// - Test-low on a port bit skips when the bit is low; flags kept.
// - Test-high on a port bit skips when the bit is high; flags kept.
// - Test-low on a memory bit skips when the bit is zero; flags kept.
// - Test-high on a memory bit skips when the bit is one; flags kept.
// - Increment accumulator, skip when result zero, update all four flags.
// - Decrement accumulator, skip when result zero, update all four flags.
// - Increment memory byte, write back, skip on zero, update all four flags.
// - Decrement memory byte, write back, skip on zero, update all four flags.
// - Call stores next address at stack, jumps, stack pointer plus two, two cycles.
// - Jump loads the target into the program counter in two cycles.
// - Return-with-value loads the accumulator then returns, two cycles.
// - Return lowers stack pointer by two, reloads program counter from stack.
// - Interrupt return resumes the program and sets global interrupt enable.
// - Computed jump adds the accumulator to the program counter in two cycles.
// - Interrupt enable lets pending requests reach the processing unit, one cycle.
// - Interrupt disable blocks all requests from the processing unit, one cycle.
// - Power-down stops system clocks and oscillators in one cycle.
// - Power-save stops system clocks and keeps oscillators running in one cycle.
// - Software reset resets the whole chip as a one-cycle instruction.
// - Watchdog clear restarts the watchdog count without touching flags.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "sbs_regs.svh"

module sbs_core (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [7:0] PORT_IN,
    input wire logic INT_REQ,
    output logic INT_TO_CPU,
    input wire logic WAKE,
    output logic CLK_STOP,
    output logic OSC_STOP,
    output logic CHIP_RST,
    output logic WDT_CLR
);

    logic [7:0] mem [0:`SBS_MEM_DEPTH-1];
    logic [7:0] acc;
    sbs_pkg::sbs_flags_type flags;
    logic [`SBS_PC_W-1:0] pc;
    logic [7:0] stack_pointer;
    logic [`SBS_MEM_AW-1:0] mem_addr;
    logic gie;
    logic discard;
    sbs_pkg::sbs_state_type state;
    sbs_pkg::sbs_instr_type instr;
    logic access;
    logic instr_wr;
    logic mapped;
    logic two_cycle;
    logic exec;
    logic skip;
    logic [7:0] mem_byte;
    logic [7:0] next_acc;
    sbs_pkg::sbs_flags_type next_flags;
    logic [`SBS_PC_W-1:0] next_pc;
    logic [7:0] next_stack_pointer;
    logic mem_we;
    logic [`SBS_MEM_AW-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic mem_we_hi;
    logic [7:0] mem_wd_hi;
    sbs_pkg::sbs_alu_type alu;

    // Add b to a, or subtract it; carry means borrow on subtraction
    function automatic sbs_pkg::sbs_alu_type alu_op(input logic [7:0] a, input logic [7:0] b, input logic sub);
        logic [8:0] full;
        logic [4:0] low;
        logic [7:0] bb;
        sbs_pkg::sbs_alu_type r;
        bb = sub ? ~b : b;
        full = {1'b0, a} + {1'b0, bb} + {8'h00, sub};
        low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
        r.value = full[7:0];
        r.flags.zero = (full[7:0] == 8'h00);
        r.flags.carry = full[8] ^ sub;
        r.flags.auxiliary_carry_flag = low[4] ^ sub;
        r.flags.overflow_flag = (a[7] == bb[7]) && (full[7] != a[7]);
        return r;
    endfunction

    // Instructions whose second cycle is fixed regardless of data
    function automatic logic fixed_two(input sbs_pkg::sbs_op_type op);
        return op inside {sbs_pkg::OP_CALL, sbs_pkg::OP_JUMP, sbs_pkg::OP_RET_VALUE, sbs_pkg::OP_RET,
                          sbs_pkg::OP_RET_INT, sbs_pkg::OP_PC_ADD};
    endfunction

    assign instr = sbs_pkg::sbs_instr_type'(PWDATA);
    assign access = PSEL && PENABLE;
    assign instr_wr = access && PWRITE && (PADDR == `SBS_ADDR_INSTR);
    assign mem_byte = mem[instr.operand[`SBS_MEM_AW-1:0]];
    assign INT_TO_CPU = INT_REQ && gie;

    // Execute datapath; all values are stable while the access phase waits
    always_comb begin
        next_acc = acc;
        next_flags = flags;
        next_pc = pc + `SBS_PC_W'(1);
        next_stack_pointer = stack_pointer;
        mem_we = 1'b0;
        mem_wa = instr.operand[`SBS_MEM_AW-1:0];
        mem_wd = 8'h00;
        mem_we_hi = 1'b0;
        mem_wd_hi = 8'h00;
        skip = 1'b0;
        alu = alu_op(acc, instr.operand[7:0], 1'b1);
        unique case (instr.op)
            sbs_pkg::OP_CMP_NE_SKIP: begin
                next_flags = alu.flags;
                skip = (acc != instr.operand[7:0]);
            end
            sbs_pkg::OP_TEST_LOW_IO: skip = !PORT_IN[instr.bit_sel];
            sbs_pkg::OP_TEST_HIGH_IO: skip = PORT_IN[instr.bit_sel];
            sbs_pkg::OP_TEST_LOW_MEM: skip = !mem_byte[instr.bit_sel];
            sbs_pkg::OP_TEST_HIGH_MEM: skip = mem_byte[instr.bit_sel];
            sbs_pkg::OP_INC_SKIP_ACC, sbs_pkg::OP_DEC_SKIP_ACC: begin
                alu = alu_op(acc, 8'h01, instr.op == sbs_pkg::OP_DEC_SKIP_ACC);
                next_acc = alu.value;
                next_flags = alu.flags;
                skip = alu.flags.zero;
            end
            sbs_pkg::OP_INC_SKIP_MEM, sbs_pkg::OP_DEC_SKIP_MEM: begin
                alu = alu_op(mem_byte, 8'h01, instr.op == sbs_pkg::OP_DEC_SKIP_MEM);
                mem_we = 1'b1;
                mem_wd = alu.value;
                next_flags = alu.flags;
                skip = alu.flags.zero;
            end
            sbs_pkg::OP_CALL: begin
                // Return address stored low byte first, high nibble in the next byte
                mem_we = 1'b1;
                mem_wa = stack_pointer[`SBS_MEM_AW-1:0];
                mem_wd = next_pc[7:0];
                mem_we_hi = 1'b1;
                mem_wd_hi = {4'h0, next_pc[11:8]};
                next_pc = instr.operand;
                next_stack_pointer = stack_pointer + `SBS_STACK_STEP;
            end
            sbs_pkg::OP_JUMP: next_pc = instr.operand;
            sbs_pkg::OP_RET_VALUE, sbs_pkg::OP_RET, sbs_pkg::OP_RET_INT: begin
                if (instr.op == sbs_pkg::OP_RET_VALUE) begin
                    next_acc = instr.operand[7:0];
                end
                next_stack_pointer = stack_pointer - `SBS_STACK_STEP;
                next_pc = {mem[next_stack_pointer[`SBS_MEM_AW-1:0] + `SBS_MEM_AW'(1)][3:0],
                           mem[next_stack_pointer[`SBS_MEM_AW-1:0]]};
            end
            sbs_pkg::OP_PC_ADD: next_pc = pc + {4'h0, acc};
            default: begin
                // Remaining system operations only touch control state below
            end
        endcase
    end

    // Skip outcome and fixed-cycle instructions hold the access phase for one extra cycle
    assign two_cycle = !discard && (fixed_two(instr.op) || skip);
    assign exec = instr_wr && PREADY;

    // APB answer: one wait state for two-cycle instructions, none otherwise
    always_comb begin
        mapped = PADDR inside {`SBS_ADDR_INSTR, `SBS_ADDR_ACC, `SBS_ADDR_FLAGS, `SBS_ADDR_PC,
                               `SBS_ADDR_STACK, `SBS_ADDR_STATUS, `SBS_ADDR_MEM_ADDR, `SBS_ADDR_MEM_DATA};
        PREADY = !(instr_wr && two_cycle && state == sbs_pkg::ST_IDLE);
        PSLVERR = access && PREADY && !mapped;
    end

    // Wait-state sequencer
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= sbs_pkg::ST_IDLE;
        end else if (access && !PREADY) begin
            state <= sbs_pkg::ST_SECOND;
        end else if (access) begin
            state <= sbs_pkg::ST_IDLE;
        end
    end

    // Skipped instruction is swallowed whole; a skip decision arms the discard
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            discard <= 1'b0;
        end else if (exec && discard) begin
            discard <= 1'b0;
        end else if (exec && instr.op != sbs_pkg::OP_SOFT_RESET) begin
            discard <= skip;
        end
    end

    // Core registers; software writes act only when no instruction executes
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            acc <= `SBS_RST_ACC;
            flags <= `SBS_RST_FLAGS;
            pc <= `SBS_RST_PC;
            stack_pointer <= `SBS_RST_STACK;
            mem_addr <= '0;
        end else if (exec && !discard && instr.op == sbs_pkg::OP_SOFT_RESET) begin
            acc <= `SBS_RST_ACC;
            flags <= `SBS_RST_FLAGS;
            pc <= `SBS_RST_PC;
            stack_pointer <= `SBS_RST_STACK;
            mem_addr <= '0;
        end else if (exec && !discard) begin
            acc <= next_acc;
            flags <= next_flags;
            pc <= skip ? next_pc + `SBS_PC_W'(1) : next_pc;
            stack_pointer <= next_stack_pointer;
        end else if (access && PWRITE) begin
            unique case (PADDR)
                `SBS_ADDR_ACC: acc <= PWDATA[7:0];
                `SBS_ADDR_FLAGS: flags <= PWDATA[3:0];
                `SBS_ADDR_PC: pc <= PWDATA[`SBS_PC_W-1:0];
                `SBS_ADDR_STACK: stack_pointer <= PWDATA[7:0];
                `SBS_ADDR_MEM_ADDR: mem_addr <= PWDATA[`SBS_MEM_AW-1:0];
                default: begin
                end
            endcase
        end
    end

    // Data memory; no reset, contents survive a chip reset like real SRAM
    always_ff @(posedge CLK) begin
        if (exec && !discard && mem_we) begin
            mem[mem_wa] <= mem_wd;
        end else if (access && PWRITE && PADDR == `SBS_ADDR_MEM_DATA) begin
            mem[mem_addr] <= PWDATA[7:0];
        end
        if (exec && !discard && mem_we_hi) begin
            mem[mem_wa + `SBS_MEM_AW'(1)] <= mem_wd_hi;
        end
    end

    // Global interrupt enable and clock-stop levels; wake-up releases the stop
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            gie <= 1'b0;
            CLK_STOP <= 1'b0;
            OSC_STOP <= 1'b0;
        end else if (exec && !discard) begin
            unique case (instr.op)
                sbs_pkg::OP_INT_ON, sbs_pkg::OP_RET_INT: gie <= 1'b1;
                sbs_pkg::OP_INT_OFF, sbs_pkg::OP_SOFT_RESET: gie <= 1'b0;
                sbs_pkg::OP_STOP_SYS: begin
                    CLK_STOP <= 1'b1;
                    OSC_STOP <= 1'b1;
                end
                sbs_pkg::OP_STOP_EXE: CLK_STOP <= 1'b1;
                default: begin
                end
            endcase
        end else if (WAKE) begin
            CLK_STOP <= 1'b0;
            OSC_STOP <= 1'b0;
        end
    end

    // One-cycle pulses to the reset and watchdog logic outside
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            CHIP_RST <= 1'b0;
            WDT_CLR <= 1'b0;
        end else begin
            CHIP_RST <= exec && !discard && instr.op == sbs_pkg::OP_SOFT_RESET;
            WDT_CLR <= exec && !discard && instr.op == sbs_pkg::OP_WDT_CLEAR;
        end
    end

    // Read data is captured in the setup cycle, so reads never wait
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            unique case (PADDR)
                `SBS_ADDR_ACC: PRDATA <= {24'h000000, acc};
                `SBS_ADDR_FLAGS: PRDATA <= {28'h0000000, flags};
                `SBS_ADDR_PC: PRDATA <= {20'h00000, pc};
                `SBS_ADDR_STACK: PRDATA <= {24'h000000, stack_pointer};
                `SBS_ADDR_STATUS: PRDATA <= {28'h0000000, discard, OSC_STOP, CLK_STOP, gie};
                `SBS_ADDR_MEM_ADDR: PRDATA <= {26'h0, mem_addr};
                `SBS_ADDR_MEM_DATA: PRDATA <= {24'h000000, mem[mem_addr]};
                default: PRDATA <= 32'h0000_0000;
            endcase
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // Results are looked at one edge after the executing access, once the registers have taken them
    a_skip_cycles: assert property (instr_wr && state == sbs_pkg::ST_IDLE && skip && !discard
        |-> !PREADY ##1 PREADY) else $error("skip did not take two cycles");
    a_test_flags_kept: assert property (exec && !discard
        && instr.op inside {sbs_pkg::OP_TEST_LOW_IO, sbs_pkg::OP_TEST_HIGH_IO, sbs_pkg::OP_TEST_LOW_MEM,
        sbs_pkg::OP_TEST_HIGH_MEM} |=> $stable(flags)) else $error("bit test changed flags");
    a_low_io_skip: assert property (exec && !discard && instr.op == sbs_pkg::OP_TEST_LOW_IO
        |=> discard == !$past(PORT_IN[instr.bit_sel])) else $error("port low test wrong");
    a_high_io_skip: assert property (exec && !discard && instr.op == sbs_pkg::OP_TEST_HIGH_IO
        |=> discard == $past(PORT_IN[instr.bit_sel])) else $error("port high test wrong");
    a_cmp_skip: assert property (exec && !discard && instr.op == sbs_pkg::OP_CMP_NE_SKIP
        |=> discard == ($past(acc) != $past(PWDATA[7:0]))) else $error("compare skip wrong");
    a_inc_acc: assert property (exec && !discard && instr.op == sbs_pkg::OP_INC_SKIP_ACC
        |=> acc == $past(acc) + 8'h01 && discard == (acc == 8'h00)) else $error("increment skip wrong");
    a_dec_acc: assert property (exec && !discard && instr.op == sbs_pkg::OP_DEC_SKIP_ACC
        |=> acc == $past(acc) - 8'h01 && discard == (acc == 8'h00)) else $error("decrement skip wrong");
    a_call_stack: assert property (exec && !discard && instr.op == sbs_pkg::OP_CALL
        |=> stack_pointer == $past(stack_pointer) + 8'h02 && pc == $past(PWDATA[11:0]))
        else $error("call did not push and jump");
    a_call_two_cycles: assert property (instr_wr && !discard && state == sbs_pkg::ST_IDLE
        && instr.op == sbs_pkg::OP_CALL |-> !PREADY ##1 PREADY) else $error("call not two cycles");
    a_jump_target: assert property (exec && !discard && instr.op == sbs_pkg::OP_JUMP
        |=> pc == $past(PWDATA[11:0]) && $stable(flags)) else $error("jump target wrong");
    a_ret_value: assert property (exec && !discard && instr.op == sbs_pkg::OP_RET_VALUE
        |=> acc == $past(PWDATA[7:0])) else $error("return value not loaded");
    a_ret_pop: assert property (exec && !discard && instr.op == sbs_pkg::OP_RET
        |=> stack_pointer == $past(stack_pointer) - 8'h02) else $error("return did not pop");
    a_reti_gie: assert property (exec && !discard && instr.op == sbs_pkg::OP_RET_INT
        |=> gie && INT_TO_CPU == INT_REQ) else $error("interrupt return left interrupts off");
    a_computed_jump: assert property (exec && !discard && instr.op == sbs_pkg::OP_PC_ADD
        |=> pc == $past(pc) + {4'h0, $past(acc)}) else $error("computed jump wrong");
    a_gie_block: assert property (exec && !discard && instr.op == sbs_pkg::OP_INT_OFF
        |=> !INT_TO_CPU) else $error("interrupt not blocked");
    a_stop_sys: assert property (exec && !discard && instr.op == sbs_pkg::OP_STOP_SYS
        |=> CLK_STOP && OSC_STOP) else $error("power-down did not stop oscillators");
    a_stop_exe: assert property (exec && !discard && instr.op == sbs_pkg::OP_STOP_EXE && !OSC_STOP
        |=> CLK_STOP && !OSC_STOP) else $error("power-save stopped oscillators");
    a_wdt_pulse: assert property (exec && !discard && instr.op == sbs_pkg::OP_WDT_CLEAR
        |=> WDT_CLR ##1 !WDT_CLR) else $error("watchdog pulse wrong");
    a_discard_inert: assert property (exec && discard
        |=> $stable(acc) && $stable(pc) && !discard) else $error("skipped instruction had an effect");

endmodule

// File: hw/sbs_regs.svh
// Register offsets, field positions, reset values and sizes of the skip and system execution unit.
// Included by the core and the testbench; holds definitions only.
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH

// APB byte addresses
`define SBS_ADDR_INSTR 8'h00
`define SBS_ADDR_ACC 8'h04
`define SBS_ADDR_FLAGS 8'h08
`define SBS_ADDR_PC 8'h0c
`define SBS_ADDR_STACK 8'h10
`define SBS_ADDR_STATUS 8'h14
`define SBS_ADDR_MEM_ADDR 8'h18
`define SBS_ADDR_MEM_DATA 8'h1c

// Status register bit positions
`define SBS_STAT_GIE 0
`define SBS_STAT_CLK_STOP 1
`define SBS_STAT_OSC_STOP 2
`define SBS_STAT_DISCARD 3

// Reset values
`define SBS_RST_ACC 8'h00
`define SBS_RST_PC 12'h000
`define SBS_RST_STACK 8'h00
`define SBS_RST_FLAGS 4'h0

// Sizes and the stack pointer step
`define SBS_MEM_DEPTH 64
`define SBS_MEM_AW 6
`define SBS_PC_W 12
`define SBS_STACK_STEP 8'h02

`endif

// File: hw/sbs_pkg.sv
// Types shared by the skip and system execution unit.
// Assumes sbs_regs.svh is on the include path.
package sbs_pkg;

    // Operation codes carried in an instruction word; unused codes act as no-operation
    typedef enum logic [4:0] {
        OP_NOP, OP_CMP_NE_SKIP, OP_TEST_LOW_IO, OP_TEST_HIGH_IO, OP_TEST_LOW_MEM,
        OP_TEST_HIGH_MEM, OP_INC_SKIP_ACC, OP_DEC_SKIP_ACC, OP_INC_SKIP_MEM, OP_DEC_SKIP_MEM,
        OP_CALL, OP_JUMP, OP_RET_VALUE, OP_RET, OP_RET_INT, OP_PC_ADD, OP_INT_ON, OP_INT_OFF,
        OP_STOP_SYS, OP_STOP_EXE, OP_SOFT_RESET, OP_WDT_CLEAR
    } sbs_op_type;

    // Instruction word as written to the instruction register
    typedef struct packed {
        logic [11:0] unused;
        sbs_op_type op;
        logic [2:0] bit_sel;
        logic [11:0] operand;
    } sbs_instr_type;

    // Arithmetic flags, bit 0 upward: zero, carry, auxiliary carry, overflow
    typedef struct packed {
        logic overflow_flag;
        logic auxiliary_carry_flag;
        logic carry;
        logic zero;
    } sbs_flags_type;

    typedef enum logic {ST_IDLE, ST_SECOND} sbs_state_type;

    // Result of an add or subtract with its flags
    typedef struct packed {
        logic [7:0] value;
        sbs_flags_type flags;
    } sbs_alu_type;

endpackage

// File: test/sbs_core_tb.sv
// Self-checking bench for the skip, branch and system-control unit.
// Assumes the design package and sbs_regs.svh are compiled and on the include path.
`timescale 1ns/1ps
`include "sbs_regs.svh"

module tb;
    logic CLK = 1'b0;
    logic SYS_RST = 1'b1;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    logic [7:0] PORT_IN = 8'h00;
    logic INT_REQ = 1'b0;
    logic INT_TO_CPU;
    logic WAKE = 1'b0;
    logic CLK_STOP;
    logic OSC_STOP;
    logic CHIP_RST;
    logic WDT_CLR;
    int errors = 0;
    int tests_run = 0;
    int waits;
    int cycles = 0;
    int rst_cnt = 0;
    int wdt_cnt = 0;

    sbs_core dut_u (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .PORT_IN(PORT_IN), .INT_REQ(INT_REQ), .INT_TO_CPU(INT_TO_CPU), .WAKE(WAKE),
        .CLK_STOP(CLK_STOP), .OSC_STOP(OSC_STOP), .CHIP_RST(CHIP_RST), .WDT_CLR(WDT_CLR));

    // 25 MHz clock
    always #20 CLK = ~CLK;

    // Pulse counters; a stuck pulse shows up as a count above one
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (CHIP_RST === 1'b1) rst_cnt <= rst_cnt + 1;
        if (WDT_CLR === 1'b1) wdt_cnt <= wdt_cnt + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; PREADY is sampled at each rising edge, and the request is held
    // until the edge at which it is high, where data is taken and the request released
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        waits = 0;
        forever begin
            @(posedge CLK);
            if (PREADY === 1'b1) break;
            waits = waits + 1;
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask

    // Executes one instruction, checks its wait states, then lets one edge pass so
    // that registered outputs launched by the executing edge have settled
    task automatic ex(input sbs_pkg::sbs_op_type op, input logic [2:0] bs, input logic [11:0] opd,
                      input int expw);
        sbs_pkg::sbs_instr_type w;
        w = '0;
        w.op = op;
        w.bit_sel = bs;
        w.operand = opd;
        wr(`SBS_ADDR_INSTR, w);
        chk(32'(waits), 32'(expw));
        @(posedge CLK);
    endtask

    task automatic wake_up();
        @(posedge CLK);
        WAKE <= 1'b1;
        @(posedge CLK);
        WAKE <= 1'b0;
        @(negedge CLK);
    endtask

    initial begin
        logic [31:0] r;
        logic e;
        repeat (20) @(posedge CLK);
        SYS_RST <= 1'b0;
        // Reset values and an unmapped address
        rc(`SBS_ADDR_ACC, 32'h0);
        rc(`SBS_ADDR_PC, 32'h0);
        rc(`SBS_ADDR_STATUS, 32'h0);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        $display("test reset done");
        // Compare-not-equal, then the discarded follower
        wr(`SBS_ADDR_ACC, 32'h10);
        ex(sbs_pkg::OP_CMP_NE_SKIP, 3'h0, 12'h055, 1);
        rc(`SBS_ADDR_FLAGS, 32'h6);
        rc(`SBS_ADDR_STATUS, 32'h8);
        ex(sbs_pkg::OP_INC_SKIP_ACC, 3'h0, 12'h000, 0);
        rc(`SBS_ADDR_ACC, 32'h10);
        rc(`SBS_ADDR_PC, 32'h2);
        wr(`SBS_ADDR_ACC, 32'h55);
        ex(sbs_pkg::OP_CMP_NE_SKIP, 3'h0, 12'h055, 0);
        rc(`SBS_ADDR_FLAGS, 32'h1);
        rc(`SBS_ADDR_PC, 32'h3);
        $display("test compare done");
        // Port and memory bit tests keep the flags
        wr(`SBS_ADDR_FLAGS, 32'ha);
        PORT_IN <= 8'h20;
        ex(sbs_pkg::OP_TEST_LOW_IO, 3'h5, 12'h000, 0);
        ex(sbs_pkg::OP_TEST_HIGH_IO, 3'h5, 12'h000, 1);
        ex(sbs_pkg::OP_NOP, 3'h0, 12'h000, 0);
        PORT_IN <= 8'hdf;
        ex(sbs_pkg::OP_TEST_LOW_IO, 3'h5, 12'h000, 1);
        ex(sbs_pkg::OP_NOP, 3'h0, 12'h000, 0);
        ex(sbs_pkg::OP_TEST_HIGH_IO, 3'h5, 12'h000, 0);
        wr(`SBS_ADDR_MEM_ADDR, 32'h3);
        wr(`SBS_ADDR_MEM_DATA, 32'h1);
        ex(sbs_pkg::OP_TEST_LOW_MEM, 3'h0, 12'h003, 0);
        ex(sbs_pkg::OP_TEST_HIGH_MEM, 3'h0, 12'h003, 1);
        ex(sbs_pkg::OP_NOP, 3'h0, 12'h000, 0);
        ex(sbs_pkg::OP_TEST_LOW_MEM, 3'h1, 12'h003, 1);
        ex(sbs_pkg::OP_NOP, 3'h0, 12'h000, 0);
        ex(sbs_pkg::OP_TEST_HIGH_MEM, 3'h1, 12'h003, 0);
        rc(`SBS_ADDR_FLAGS, 32'ha);
        $display("test bit tests done");
        // Increment and decrement with skip on zero
        wr(`SBS_ADDR_ACC, 32'hff);
        ex(sbs_pkg::OP_INC_SKIP_ACC, 3'h0, 12'h000, 1);
        ex(sbs_pkg::OP_NOP, 3'h0, 12'h000, 0);
        rc(`SBS_ADDR_ACC, 32'h0);
        rc(`SBS_ADDR_FLAGS, 32'h7);
        wr(`SBS_ADDR_ACC, 32'h80);
        ex(sbs_pkg::OP_DEC_SKIP_ACC, 3'h0, 12'h000, 0);
        rc(`SBS_ADDR_ACC, 32'h7f);
        rc(`SBS_ADDR_FLAGS, 32'hc);
        wr(`SBS_ADDR_MEM_ADDR, 32'h5);
        wr(`SBS_ADDR_MEM_DATA, 32'h7f);
        ex(sbs_pkg::OP_INC_SKIP_MEM, 3'h0, 12'h005, 0);
        rc(`SBS_ADDR_MEM_DATA, 32'h80);
        rc(`SBS_ADDR_FLAGS, 32'hc);
        wr(`SBS_ADDR_MEM_DATA, 32'h1);
        ex(sbs_pkg::OP_DEC_SKIP_MEM, 3'h0, 12'h005, 1);
        ex(sbs_pkg::OP_NOP, 3'h0, 12'h000, 0);
        rc(`SBS_ADDR_MEM_DATA, 32'h0);
        rc(`SBS_ADDR_FLAGS, 32'h1);
        $display("test count skips done");
        // Call, returns, jump and computed jump; flags must survive all of them
        wr(`SBS_ADDR_PC, 32'h123);
        wr(`SBS_ADDR_STACK, 32'h10);
        wr(`SBS_ADDR_FLAGS, 32'h5);
        ex(sbs_pkg::OP_CALL, 3'h0, 12'h456, 1);
        rc(`SBS_ADDR_PC, 32'h456);
        rc(`SBS_ADDR_STACK, 32'h12);
        wr(`SBS_ADDR_MEM_ADDR, 32'h10);
        rc(`SBS_ADDR_MEM_DATA, 32'h24);
        wr(`SBS_ADDR_MEM_ADDR, 32'h11);
        rc(`SBS_ADDR_MEM_DATA, 32'h1);
        ex(sbs_pkg::OP_RET, 3'h0, 12'h000, 1);
        rc(`SBS_ADDR_PC, 32'h124);
        rc(`SBS_ADDR_STACK, 32'h10);
        ex(sbs_pkg::OP_CALL, 3'h0, 12'h200, 1);
        ex(sbs_pkg::OP_RET_VALUE, 3'h0, 12'h05a, 1);
        rc(`SBS_ADDR_ACC, 32'h5a);
        rc(`SBS_ADDR_PC, 32'h125);
        ex(sbs_pkg::OP_JUMP, 3'h0, 12'h3ff, 1);
        rc(`SBS_ADDR_PC, 32'h3ff);
        wr(`SBS_ADDR_ACC, 32'h10);
        ex(sbs_pkg::OP_PC_ADD, 3'h0, 12'h000, 1);
        rc(`SBS_ADDR_PC, 32'h40f);
        rc(`SBS_ADDR_FLAGS, 32'h5);
        $display("test branches done");
        // Global interrupt enable paths
        INT_REQ <= 1'b1;
        ex(sbs_pkg::OP_INT_ON, 3'h0, 12'h000, 0);
        chk(32'(INT_TO_CPU), 32'h1);
        ex(sbs_pkg::OP_INT_OFF, 3'h0, 12'h000, 0);
        chk(32'(INT_TO_CPU), 32'h0);
        ex(sbs_pkg::OP_CALL, 3'h0, 12'h300, 1);
        ex(sbs_pkg::OP_RET_INT, 3'h0, 12'h000, 1);
        chk(32'(INT_TO_CPU), 32'h1);
        rc(`SBS_ADDR_PC, 32'h412);
        $display("test interrupts done");
        // Clock stop modes, watchdog clear and software reset
        ex(sbs_pkg::OP_STOP_SYS, 3'h0, 12'h000, 0);
        chk(32'({CLK_STOP, OSC_STOP}), 32'h3);
        wake_up();
        ex(sbs_pkg::OP_STOP_EXE, 3'h0, 12'h000, 0);
        chk(32'({CLK_STOP, OSC_STOP}), 32'h2);
        wake_up();
        ex(sbs_pkg::OP_WDT_CLEAR, 3'h0, 12'h000, 0);
        repeat (2) @(posedge CLK);
        chk(32'(wdt_cnt), 32'h1);
        rc(`SBS_ADDR_FLAGS, 32'h5);
        ex(sbs_pkg::OP_SOFT_RESET, 3'h0, 12'h000, 0);
        repeat (2) @(posedge CLK);
        chk(32'(rst_cnt), 32'h1);
        rc(`SBS_ADDR_ACC, 32'h0);
        rc(`SBS_ADDR_PC, 32'h0);
        $display("test system done");
        summarize();
    end
endmodule
